// [nce_defs.svh]
// Field widths, offsets and register map of the neighbour cell element codec
`ifndef NCE_DEFS_SVH
`define NCE_DEFS_SVH
`define W_LATE        1
`define W_LA          14
`define W_CARRIER     12
`define W_BAND        4
`define W_OFFSET      2
`define W_DUPLEX      3
`define W_REVERSE     1
`define W_EXT         10
`define W_RXLEV       4
`define W_TXPWR       3
`define W_CC          10
`define W_NC          14
`define W_CELL_ID     5
`define W_RESEL       2
`define W_SYNC        1
`define W_SVC         2
`define W_MAND        22
`define W_NCI_MAX     74
`define LEN_W         7
`define TXPWR_RSVD    3'h0
`define CELL_ENQUIRY  5'h00
`define A_CTRL        8'h00
`define A_STATUS      8'h04
`define A_MAND        8'h08
`define A_EXT         8'h0C
`define A_CC_NC       8'h10
`define A_LA          8'h14
`define A_SRV_CC_NC   8'h18
`define A_SRV_LA_EXT  8'h1C
`define A_BITS_HI     8'h20
`define A_BITS_MID    8'h24
`define A_BITS_LO     8'h28
`define A_BITS_LEN    8'h2C
`define A_CELL_MISC   8'h30
`define A_DEC_MAND    8'h34
`define A_DEC_EXT     8'h38
`define A_DEC_CC_NC   8'h3C
`define A_DEC_LA      8'h40
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

// [nce_pkg.sv]
// Types of the neighbour cell element codec
package nce_pkg;
    typedef enum logic [1:0] {
        OFS_NONE  = 2'b00,
        OFS_P6K25 = 2'b01,
        OFS_M6K25 = 2'b10,
        OFS_P12K5 = 2'b11
    } carrier_offset_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_DONE = 2'b10
    } codec_state_t;
endpackage : nce_pkg

// [nce_parser.sv]
// Neighbour cell element parser: unpacks a left-aligned bit string
`timescale 1ns/1ps
`include "nce_defs.svh"
module nce_parser
    import nce_pkg::*;
#(
    parameter int NCI_W = `W_NCI_MAX
) (
    input  wire logic [NCI_W-1:0]        bits,
    input  wire logic [`W_EXT-1:0]       srv_ext,
    input  wire logic [`W_CC-1:0]        srv_cc,
    input  wire logic [`W_NC-1:0]        srv_nc,
    input  wire logic [`W_LA-1:0]        srv_la,
    output logic      [`W_MAND-1:0]      mand,
    output logic      [3:0]              present,
    output logic      [`W_EXT-1:0]       ext,
    output logic      [`W_CC-1:0]        cc,
    output logic      [`W_NC-1:0]        nc,
    output logic      [`W_LA-1:0]        la,
    output logic      [`LEN_W-1:0]       used_len,
    output logic                         enquiry
);
    initial begin
        if (NCI_W != `W_NCI_MAX) $error("nce_parser: NCI_W must be 74");
    end

    // Walks presence flags in element order, so field positions follow flags
    always_comb begin
        int p;
        p        = NCI_W;
        mand     = bits[NCI_W-1 -: `W_MAND];
        p        = p - `W_MAND;
        ext      = srv_ext;
        cc       = srv_cc;
        nc       = srv_nc;
        la       = srv_la;
        present  = 4'h0;
        present[3] = bits[p-1];
        p = p - 1;
        if (present[3]) begin
            ext = bits[p-1 -: `W_EXT];
            p   = p - `W_EXT;
        end
        present[2] = bits[p-1];
        p = p - 1;
        if (present[2]) begin
            cc = bits[p-1 -: `W_CC];
            p  = p - `W_CC;
        end
        present[1] = bits[p-1];
        p = p - 1;
        if (present[1]) begin
            nc = bits[p-1 -: `W_NC];
            p  = p - `W_NC;
        end
        present[0] = bits[p-1];
        p = p - 1;
        if (present[0]) begin
            la = bits[p-1 -: `W_LA];
            p  = p - `W_LA;
        end
        // Absent fields keep the serving cell values set above
        used_len = `LEN_W'(NCI_W - p);
        enquiry  = (mand[`W_MAND-1 -: `W_CELL_ID] == `CELL_ENQUIRY);
    end
endmodule : nce_parser

// [nce_codec.sv]
// Neighbour cell element codec with AXI4-Lite register access
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "nce_defs.svh"
module nce_codec
    import nce_pkg::*;
#(
    parameter int NCI_W = `W_NCI_MAX
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY
);
    initial begin
        if (NCI_W != `W_NCI_MAX) $error("nce_codec: NCI_W must be 74");
    end

    logic [`W_MAND-1:0]  mand_q;
    logic [3:0]          pres_q;
    logic [`W_EXT-1:0]   ext_q;
    logic [`W_CC-1:0]    cc_q;
    logic [`W_NC-1:0]    nc_q;
    logic [`W_LA-1:0]    la_q;
    logic [`W_EXT-1:0]   srv_ext_q;
    logic [`W_CC-1:0]    srv_cc_q;
    logic [`W_NC-1:0]    srv_nc_q;
    logic [`W_LA-1:0]    srv_la_q;
    logic [NCI_W-1:0]    bits_q;
    logic [`LEN_W-1:0]   len_q;
    logic [`W_LATE-1:0]  late_q;
    logic [`W_RXLEV-1:0] rxlev_q;
    logic [`W_TXPWR-1:0] txpwr_q;
    logic [1:0]          bcast_q;
    logic                build_err_q;
    logic [`W_MAND-1:0]  p_mand;
    logic [3:0]          p_pres;
    logic [`W_EXT-1:0]   p_ext;
    logic [`W_CC-1:0]    p_cc;
    logic [`W_NC-1:0]    p_nc;
    logic [`W_LA-1:0]    p_la;
    logic [`LEN_W-1:0]   p_len;
    logic                p_enq;
    logic [NCI_W-1:0]    build_d;
    logic [`LEN_W-1:0]   build_len_d;

    // AXI4-Lite write path
    logic       aw_hold_q;
    logic       w_hold_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        wr_fire;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        wr_hit;

    assign S_AXI_AWREADY = !aw_hold_q && !bvalid_q;
    assign S_AXI_WREADY  = !w_hold_q && !bvalid_q;
    assign S_AXI_BVALID  = bvalid_q;
    assign S_AXI_BRESP   = bresp_q;
    assign wr_fire       = aw_hold_q && w_hold_q;

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end else if (wr_fire) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_hold_q <= 1'b1;
                w_data_q <= S_AXI_WDATA;
                w_strb_q <= S_AXI_WSTRB;
            end
        end
    end

    always_comb begin
        unique case (aw_addr_q)
            `A_CTRL, `A_MAND, `A_EXT, `A_CC_NC, `A_LA, `A_SRV_CC_NC, `A_SRV_LA_EXT,
            `A_BITS_HI, `A_BITS_MID, `A_BITS_LO, `A_CELL_MISC: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            bvalid_q <= 1'b0;
        end
    end

    // Full-word writes only; partial strobes would split packed fields
    logic wr_ok;
    logic build_go;
    logic parse_go;
    assign wr_ok    = wr_fire && (w_strb_q == 4'hF);
    assign build_go = wr_ok && aw_addr_q == `A_CTRL && w_data_q[0];
    assign parse_go = wr_ok && aw_addr_q == `A_CTRL && w_data_q[1];

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            mand_q    <= '0;
            pres_q    <= 4'h0;
            ext_q     <= '0;
            cc_q      <= '0;
            nc_q      <= '0;
            la_q      <= '0;
            srv_ext_q <= '0;
            srv_cc_q  <= '0;
            srv_nc_q  <= '0;
            srv_la_q  <= '0;
            late_q    <= '0;
            rxlev_q   <= '0;
            txpwr_q   <= 3'h1;
            bcast_q   <= 2'h0;
        end else if (wr_ok) begin
            unique case (aw_addr_q)
                `A_MAND: begin
                    mand_q <= w_data_q[`W_MAND-1:0];
                    pres_q <= w_data_q[27:24];
                end
                `A_EXT: ext_q <= w_data_q[`W_EXT-1:0];
                `A_CC_NC: begin
                    nc_q <= w_data_q[`W_NC-1:0];
                    cc_q <= w_data_q[16 +: `W_CC];
                end
                `A_LA: la_q <= w_data_q[`W_LA-1:0];
                `A_SRV_CC_NC: begin
                    srv_nc_q <= w_data_q[`W_NC-1:0];
                    srv_cc_q <= w_data_q[16 +: `W_CC];
                end
                `A_SRV_LA_EXT: begin
                    srv_la_q  <= w_data_q[`W_LA-1:0];
                    srv_ext_q <= w_data_q[16 +: `W_EXT];
                end
                `A_CELL_MISC: begin
                    late_q  <= w_data_q[0];
                    bcast_q <= w_data_q[2:1];
                    rxlev_q <= w_data_q[7:4];
                    txpwr_q <= w_data_q[10:8];
                end
                default: ;
            endcase
        end
    end

    // Builder: mandatory part, then flag plus optional field per type 2 entry
    always_comb begin
        int p;
        p       = NCI_W - `W_MAND;
        build_d = '0;
        build_d[NCI_W-1 -: `W_MAND] = mand_q;
        build_d[p-1] = pres_q[3];
        p = p - 1;
        if (pres_q[3]) begin
            build_d[p-1 -: `W_EXT] = ext_q;
            p = p - `W_EXT;
        end
        build_d[p-1] = pres_q[2];
        p = p - 1;
        if (pres_q[2]) begin
            build_d[p-1 -: `W_CC] = cc_q;
            p = p - `W_CC;
        end
        build_d[p-1] = pres_q[1];
        p = p - 1;
        if (pres_q[1]) begin
            build_d[p-1 -: `W_NC] = nc_q;
            p = p - `W_NC;
        end
        build_d[p-1] = pres_q[0];
        p = p - 1;
        if (pres_q[0]) begin
            build_d[p-1 -: `W_LA] = la_q;
            p = p - `W_LA;
        end
        build_len_d = `LEN_W'(NCI_W - p);
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            bits_q      <= '0;
            len_q       <= '0;
            build_err_q <= 1'b0;
        end else if (build_go) begin
            bits_q      <= build_d;
            len_q       <= build_len_d;
            build_err_q <= (txpwr_q == `TXPWR_RSVD);
        end else if (parse_go) begin
            // Parse strobe is itself a register write, so it must win over the bits writes; a build strobe still wins over it
            len_q <= p_len;
        end else if (wr_ok) begin
            unique case (aw_addr_q)
                `A_BITS_HI:  bits_q[NCI_W-1 -: 32] <= w_data_q;
                `A_BITS_MID: bits_q[NCI_W-33 -: 32] <= w_data_q;
                `A_BITS_LO:  bits_q[NCI_W-65:0] <= w_data_q[NCI_W-65:0];
                default: ;
            endcase
        end
    end

    nce_parser #(
        .NCI_W (NCI_W)
    ) u_parser (
        .bits     (bits_q),
        .srv_ext  (srv_ext_q),
        .srv_cc   (srv_cc_q),
        .srv_nc   (srv_nc_q),
        .srv_la   (srv_la_q),
        .mand     (p_mand),
        .present  (p_pres),
        .ext      (p_ext),
        .cc       (p_cc),
        .nc       (p_nc),
        .la       (p_la),
        .used_len (p_len),
        .enquiry  (p_enq)
    );

    // Read path; one read outstanding, RDATA registered
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic [31:0] rd_d;
    logic        rd_hit;

    assign S_AXI_ARREADY = !rvalid_q;
    assign S_AXI_RVALID  = rvalid_q;
    assign S_AXI_RDATA   = rdata_q;
    assign S_AXI_RRESP   = rresp_q;

    always_comb begin
        rd_d   = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (S_AXI_ARADDR)
            `A_CTRL:       rd_d = 32'h0000_0000;
            `A_STATUS:     rd_d = {28'h0, build_err_q, p_enq, !bcast_q[0], bcast_q[1]};
            `A_MAND:       rd_d = {4'h0, pres_q, 2'h0, mand_q};
            `A_EXT:        rd_d = {22'h0, ext_q};
            `A_CC_NC:      rd_d = {6'h0, cc_q, 2'h0, nc_q};
            `A_LA:         rd_d = {18'h0, la_q};
            `A_SRV_CC_NC:  rd_d = {6'h0, srv_cc_q, 2'h0, srv_nc_q};
            `A_SRV_LA_EXT: rd_d = {6'h0, srv_ext_q, 2'h0, srv_la_q};
            `A_BITS_HI:    rd_d = bits_q[NCI_W-1 -: 32];
            `A_BITS_MID:   rd_d = bits_q[NCI_W-33 -: 32];
            `A_BITS_LO:    rd_d = {22'h0, bits_q[NCI_W-65:0]};
            `A_BITS_LEN:   rd_d = {25'h0, len_q};
            `A_CELL_MISC:  rd_d = {21'h0, txpwr_q, rxlev_q, 1'b0, bcast_q, late_q};
            `A_DEC_MAND:   rd_d = {4'h0, p_pres, 2'h0, p_mand};
            `A_DEC_EXT:    rd_d = {22'h0, p_ext};
            `A_DEC_CC_NC:  rd_d = {6'h0, p_cc, 2'h0, p_nc};
            `A_DEC_LA:     rd_d = {18'h0, p_la};
            default:       rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_d;
            rresp_q  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

    a_build_len: assert property (@(posedge SYS_CLK) disable iff (RST)
        build_go |=> len_q == `LEN_W'(`W_MAND + 4 + ($past(pres_q[3]) ? 10 : 0) + ($past(pres_q[2]) ? 10 : 0)
                               + ($past(pres_q[1]) ? 14 : 0) + ($past(pres_q[0]) ? 14 : 0)))
        else $error("built length wrong");
    a_mand_first: assert property (@(posedge SYS_CLK) disable iff (RST)
        build_go |=> bits_q[NCI_W-1 -: `W_MAND] == $past(mand_q))
        else $error("mandatory part misplaced");
    a_flag_ext: assert property (@(posedge SYS_CLK) disable iff (RST)
        build_go |=> bits_q[NCI_W-`W_MAND-1] == $past(pres_q[3]))
        else $error("extension flag misplaced");
    a_absent_srv: assert property (@(posedge SYS_CLK) disable iff (RST)
        !p_pres[0] |-> p_la == srv_la_q)
        else $error("absent area not serving value");
    a_enquiry_id: assert property (@(posedge SYS_CLK) disable iff (RST)
        p_enq == (bits_q[NCI_W-1 -: 5] == 5'h00))
        else $error("enquiry decode wrong");
    a_txpwr_err: assert property (@(posedge SYS_CLK) disable iff (RST)
        build_go && txpwr_q == 3'h0 |=> build_err_q)
        else $error("reserved power not flagged");
    a_round_trip: assert property (@(posedge SYS_CLK) disable iff (RST)
        build_go |=> p_pres == $past(pres_q) && (!p_pres[2] || p_cc == $past(cc_q)))
        else $error("parse of built element differs");
    a_bresp_hold: assert property (@(posedge SYS_CLK) disable iff (RST)
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped");
endmodule : nce_codec

// [nce_peer.sv]
// Peer entity model: packs neighbour cell elements bit by bit
`timescale 1ns/1ps
module nce_peer;
    function automatic void put(ref bit q[$], input logic [21:0] v, input int w);
        for (int k = w - 1; k >= 0; k--) begin
            q.push_back(v[k]);
        end
    endfunction : put

    // Left-aligned element; trailing bits stay zero
    function automatic logic [73:0] pack(input logic [21:0] mand, input logic [3:0] pres,
                                         input logic [9:0] ext, input logic [9:0] cc,
                                         input logic [13:0] nc, input logic [13:0] la, output int len);
        bit          q[$];
        logic [73:0] v;
        put(q, mand, 22);
        put(q, pres[3], 1);
        if (pres[3]) put(q, ext, 10);
        put(q, pres[2], 1);
        if (pres[2]) put(q, cc, 10);
        put(q, pres[1], 1);
        if (pres[1]) put(q, nc, 14);
        put(q, pres[0], 1);
        if (pres[0]) put(q, la, 14);
        len = q.size();
        v = '0;
        foreach (q[i]) v[73 - i] = q[i];
        return v;
    endfunction : pack
endmodule : nce_peer

// [tb_top.sv]
// Self-checking testbench of the neighbour cell element codec
`timescale 1ns/1ps
`include "nce_defs.svh"
module tb_top import nce_pkg::*;;
    logic        SYS_CLK = 1'b0;
    logic        RST = 1'b1;
    logic [7:0]  S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
    logic [31:0] S_AXI_WDATA = 32'h0;
    logic [3:0]  S_AXI_WSTRB = 4'hF;
    logic        S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
    logic        S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
    logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
    logic [31:0] S_AXI_RDATA;
    int          err_count = 0;
    int          num_checks = 0;

    nce_codec #(.NCI_W(`W_NCI_MAX)) i_nce_codec (
        .SYS_CLK(SYS_CLK), .RST(RST),
        .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
        .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
        .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
        .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
        .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
        .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY)
    );
    nce_peer i_peer ();

    always #5 SYS_CLK = ~SYS_CLK;

    task automatic bad(input string msg);
        err_count++;
        $display("BAD %0t %s", $time, msg);
    endtask : bad

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) bad($sformatf("data %h expected %h", got, exp));
    endtask : chk_data

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        num_checks++;
        if (got !== exp) bad($sformatf("response %h expected %h", got, exp));
    endtask : chk_resp

    // Readies are sampled at the edge; payload released only once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge SYS_CLK);
        S_AXI_AWADDR  <= a;
        S_AXI_WDATA   <= d;
        S_AXI_WSTRB   <= s;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID  <= 1'b1;
        S_AXI_BREADY  <= 1'b1;
        do begin
            @(posedge SYS_CLK);
            n++;
            if (S_AXI_AWVALID && S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WVALID && S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 1'b0;
        end while (S_AXI_BVALID !== 1'b1 && n < 64);
        if (S_AXI_BVALID !== 1'b1) bad("write without response");
        r = S_AXI_BRESP;
        S_AXI_BREADY <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge SYS_CLK);
        S_AXI_ARADDR  <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY  <= 1'b1;
        do begin
            @(posedge SYS_CLK);
            n++;
            if (S_AXI_ARVALID && S_AXI_ARREADY === 1'b1) S_AXI_ARVALID <= 1'b0;
        end while (S_AXI_RVALID !== 1'b1 && n < 64);
        if (S_AXI_RVALID !== 1'b1) bad("read without response");
        d = S_AXI_RDATA;
        r = S_AXI_RRESP;
        S_AXI_RREADY <= 1'b0;
    endtask : rd

    task automatic wrk(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, 4'hF, r);
    endtask : wrk

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk_data(d, exp);
    endtask : rdc

    task automatic end_test(input string nm);
        $display("test %s done, checks %0d errors %0d", nm, num_checks, err_count);
    endtask : end_test

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    // Whole run is about twelve hundred cycles; twenty thousand is ample
    initial begin
        #200000;
        bad("watchdog expired");
        finish_test();
    end

    initial begin
        logic [1:0]  r;
        logic [31:0] d;
        logic [21:0] m;
        logic [3:0]  p;
        logic [9:0]  ex, cc, sx, scc;
        logic [13:0] nc, la, snc, sla;
        logic [73:0] e;
        int          len;
        void'($urandom(97165));
        repeat (20) @(posedge SYS_CLK);
        RST <= 1'b0;
        rdc(`A_CELL_MISC, 32'h0000_0100);
        rdc(`A_MAND, 32'h0);
        rdc(`A_BITS_LEN, 32'h0);
        rdc(`A_CTRL, 32'h0);
        end_test("reset");
        sx  = 10'($urandom);
        scc = 10'($urandom);
        snc = 14'($urandom);
        sla = 14'($urandom);
        wrk(`A_SRV_CC_NC, {6'h0, scc, 2'h0, snc});
        wrk(`A_SRV_LA_EXT, {6'h0, sx, 2'h0, sla});
        rdc(`A_SRV_CC_NC, {6'h0, scc, 2'h0, snc});
        rdc(`A_SRV_LA_EXT, {6'h0, sx, 2'h0, sla});
        // Every power code, the reserved one included
        for (int t = 0; t < 8; t++) begin
            d = {21'h0, 3'(t), 4'($urandom), 1'b0, 3'($urandom)};
            wrk(`A_CELL_MISC, d);
            rdc(`A_CELL_MISC, d);
            wrk(`A_CTRL, 32'h1);
            rd(`A_STATUS, e[31:0], r);
            chk_data(e[31:0] & 32'hB, {28'h0, t == 0, 1'b0, !d[1], d[2]});
        end
        end_test("cell_misc");
        // Every presence pattern; offset codes cycle through all four
        for (int i = 0; i < 16; i++) begin
            m  = {(i % 5 == 0) ? 5'h00 : 5'($urandom_range(1, 31)), 17'($urandom)};
            p  = i[3:0];
            ex = {4'($urandom), carrier_offset_t'(i[1:0]), 3'($urandom), i[2]};
            cc = 10'($urandom);
            nc = 14'($urandom);
            la = 14'($urandom);
            wrk(`A_MAND, {4'h0, p, 2'h0, m});
            wrk(`A_EXT, {22'h0, ex});
            wrk(`A_CC_NC, {6'h0, cc, 2'h0, nc});
            wrk(`A_LA, {18'h0, la});
            wrk(`A_CTRL, 32'h1);
            e = i_peer.pack(m, p, ex, cc, nc, la, len);
            rdc(`A_BITS_HI, e[73:42]);
            rdc(`A_BITS_MID, e[41:10]);
            rdc(`A_BITS_LO, {22'h0, e[9:0]});
            rdc(`A_BITS_LEN, 32'(len));
            p = ~i[3:0];
            e = i_peer.pack(m, p, ex, cc, nc, la, len);
            wrk(`A_BITS_HI, e[73:42]);
            wrk(`A_BITS_MID, e[41:10]);
            wrk(`A_BITS_LO, {22'h0, e[9:0]});
            wrk(`A_CTRL, 32'h2);
            rdc(`A_DEC_MAND, {4'h0, p, 2'h0, m});
            rdc(`A_DEC_EXT, {22'h0, p[3] ? ex : sx});
            rdc(`A_DEC_CC_NC, {6'h0, p[2] ? cc : scc, 2'h0, p[1] ? nc : snc});
            rdc(`A_DEC_LA, {18'h0, p[0] ? la : sla});
            rdc(`A_BITS_LEN, 32'(len));
            rd(`A_STATUS, d, r);
            chk_data({31'h0, d[2]}, {31'h0, m[21:17] == 5'h00});
        end
        end_test("build_parse");
        wr(8'h44, 32'hFFFF_FFFF, 4'hF, r);
        chk_resp(r, `RESP_SLVERR);
        rd(8'h44, d, r);
        chk_resp(r, `RESP_SLVERR);
        chk_data(d, 32'h0);
        wr(`A_LA, 32'h0000_1234, 4'h3, r);
        chk_resp(r, `RESP_OKAY);
        rdc(`A_LA, {18'h0, la});
        end_test("bus_errors");
        finish_test();
    end
endmodule : tb_top
